//--- core/scp_cfg_regs.sv
module scp_cfg_regs #(
	parameter int RAMP_STEP_CYCLES = 4
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [scp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [scp_pkg::DATA_W-1:0] WDATA,
	output logic [scp_pkg::DATA_W-1:0] RDATA,
	input wire logic IRQ_EVENT,
	input wire logic INPUT_IS_19M44,
	input wire logic OFFSET_CHANGED,
	input wire logic [1:0] SYNC_SELECT,
	output logic [1:0] SAMPLE_PRECISION,
	output logic OCN_ALIGN_EN,
	output logic signed [3:0] SAMPLE_OFFSET,
	output logic [2:0] MONITOR_LIMIT,
	output logic HOLDOVER_REQ,
	output logic DIVIDER_RESET,
	output logic OFFSET_RAMP_ACTIVE,
	output logic OFFSET_AT_ZERO,
	output logic IRQ_PIN_O,
	output logic IRQ_PIN_OE
);
	typedef enum {CAL_IDLE, CAL_ENTER, CAL_TO_ZERO, CAL_DIV_RST, CAL_TO_PROG, CAL_LEAVE} scp_cal_t;

	logic [7:0] sync_phase_r;
	logic [7:0] sync_mon_r;
	logic [7:0] irq_cfg_r;
	logic [7:0] guard_r;
	logic single_used_r;
	logic write_ok;
	logic wr_cfg;
	logic signed [3:0] dec_off [3];
	logic [$clog2(RAMP_STEP_CYCLES+1)-1:0] ramp_cnt_r;
	logic auto_ramp_r;
	scp_cal_t cal_r;
	scp_cal_t cal_nxt;
	logic ramp_done;
	logic irq_active;

	// Write acceptance by guard key; the key register itself is always writable
	always_comb begin
		write_ok = 1'b0;
		if (guard_r == scp_pkg::KEY_FULL_OPEN) begin
			write_ok = 1'b1;
		end else if (guard_r == scp_pkg::KEY_SINGLE_OPEN) begin
			write_ok = !single_used_r;
		end
	end

	assign wr_cfg = WR_EN && write_ok && (ADDR != scp_pkg::OFS_GUARD);

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			guard_r <= scp_pkg::RST_GUARD;
			single_used_r <= 1'b0;
		end else if (WR_EN && ADDR == scp_pkg::OFS_GUARD) begin
			guard_r <= WDATA;
			single_used_r <= 1'b0;
		end else if (wr_cfg && (ADDR == scp_pkg::OFS_SYNC_PHASE || ADDR == scp_pkg::OFS_SYNC_MON
				|| ADDR == scp_pkg::OFS_IRQ_CFG) && guard_r == scp_pkg::KEY_SINGLE_OPEN) begin
			single_used_r <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sync_phase_r <= scp_pkg::RST_SYNC_PHASE;
			sync_mon_r <= scp_pkg::RST_SYNC_MON;
			irq_cfg_r <= scp_pkg::RST_IRQ_CFG;
		end else if (wr_cfg) begin
			case (ADDR)
				scp_pkg::OFS_SYNC_PHASE: sync_phase_r <= WDATA;
				scp_pkg::OFS_SYNC_MON: sync_mon_r <= (WDATA & scp_pkg::MASK_SYNC_MON)
					| (sync_mon_r & ~scp_pkg::MASK_SYNC_MON);
				scp_pkg::OFS_IRQ_CFG: irq_cfg_r <= WDATA & scp_pkg::MASK_IRQ_CFG;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 8'h00;
		end else if (RD_EN) begin
			case (ADDR)
				scp_pkg::OFS_SYNC_PHASE: RDATA <= sync_phase_r;
				scp_pkg::OFS_SYNC_MON: RDATA <= sync_mon_r;
				scp_pkg::OFS_IRQ_CFG: RDATA <= irq_cfg_r;
				scp_pkg::OFS_GUARD: RDATA <= guard_r;
				default: RDATA <= 8'h00;
			endcase
		end
	end

	// One decoder per sync input
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_dec
			scp_phase_dec u_dec (
				.CORE_CLK(CORE_CLK),
				.NRST(NRST),
				.code(sync_phase_r[2*gi+1:2*gi]),
				.offset_r(dec_off[gi])
			);
		end
	endgenerate

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			SAMPLE_PRECISION <= scp_pkg::PREC_6M48;
			OCN_ALIGN_EN <= 1'b0;
			SAMPLE_OFFSET <= 4'sh0;
			MONITOR_LIMIT <= 3'h0;
		end else begin
			OCN_ALIGN_EN <= sync_phase_r[scp_pkg::BIT_DERIVED_RATE];
			if (!sync_phase_r[scp_pkg::BIT_DERIVED_RATE]) begin
				SAMPLE_PRECISION <= scp_pkg::PREC_6M48;
			end else if (INPUT_IS_19M44) begin
				SAMPLE_PRECISION <= scp_pkg::PREC_19M44;
			end else begin
				SAMPLE_PRECISION <= scp_pkg::PREC_38M88;
			end
			SAMPLE_OFFSET <= (SYNC_SELECT < 2'h3) ? dec_off[SYNC_SELECT] : 4'sh0;
			MONITOR_LIMIT <= sync_mon_r[scp_pkg::MON_LIMIT_LSB +: 3];
		end
	end

	// Ramp timer shared by automatic ramping and calibration steps
	assign ramp_done = (ramp_cnt_r == '0);

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ramp_cnt_r <= '0;
			auto_ramp_r <= 1'b0;
		end else if (cal_r == CAL_IDLE && !sync_mon_r[scp_pkg::BIT_CAL_START] && OFFSET_CHANGED) begin
			ramp_cnt_r <= ($clog2(RAMP_STEP_CYCLES+1))'(RAMP_STEP_CYCLES);
			auto_ramp_r <= 1'b1;
		end else if (cal_nxt != cal_r && (cal_nxt == CAL_TO_ZERO || cal_nxt == CAL_TO_PROG)) begin
			ramp_cnt_r <= ($clog2(RAMP_STEP_CYCLES+1))'(RAMP_STEP_CYCLES);
			auto_ramp_r <= 1'b0;
		end else if (!ramp_done) begin
			ramp_cnt_r <= ramp_cnt_r - 1'b1;
		end else begin
			auto_ramp_r <= 1'b0;
		end
	end

	// Calibration starts on any accepted write of the ramp control bit as 1 while idle, even when it is already set
	always_comb begin
		cal_nxt = cal_r;
		case (cal_r)
			CAL_IDLE: if (wr_cfg && ADDR == scp_pkg::OFS_SYNC_MON && WDATA[scp_pkg::BIT_CAL_START])
				cal_nxt = CAL_ENTER;
			CAL_ENTER: cal_nxt = CAL_TO_ZERO;
			CAL_TO_ZERO: if (ramp_done) cal_nxt = CAL_DIV_RST;
			CAL_DIV_RST: cal_nxt = CAL_TO_PROG;
			CAL_TO_PROG: if (ramp_done) cal_nxt = CAL_LEAVE;
			CAL_LEAVE: cal_nxt = CAL_IDLE;
			default: cal_nxt = CAL_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			cal_r <= CAL_IDLE;
			HOLDOVER_REQ <= 1'b0;
			DIVIDER_RESET <= 1'b0;
			OFFSET_RAMP_ACTIVE <= 1'b0;
			OFFSET_AT_ZERO <= 1'b0;
		end else begin
			cal_r <= cal_nxt;
			HOLDOVER_REQ <= (cal_nxt != CAL_IDLE);
			DIVIDER_RESET <= (cal_nxt == CAL_DIV_RST);
			OFFSET_AT_ZERO <= (cal_nxt == CAL_DIV_RST);
			OFFSET_RAMP_ACTIVE <= auto_ramp_r || cal_nxt == CAL_TO_ZERO
				|| cal_nxt == CAL_TO_PROG;
		end
	end

	// Interrupt pin: active level by polarity, drive policy by tristate
	assign irq_active = irq_cfg_r[scp_pkg::BIT_PIN_AS_OUTPUT] || IRQ_EVENT;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			IRQ_PIN_O <= 1'b1;
			IRQ_PIN_OE <= 1'b0;
		end else begin
			IRQ_PIN_O <= irq_active ? irq_cfg_r[scp_pkg::BIT_POLARITY]
				: !irq_cfg_r[scp_pkg::BIT_POLARITY];
			IRQ_PIN_OE <= irq_active || !irq_cfg_r[scp_pkg::BIT_TRISTATE];
		end
	end
endmodule

//--- core/scp_phase_dec.sv
// Turns one two-bit sampling phase code into a signed offset in half-UI steps
module scp_phase_dec (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [1:0] code,
	output logic signed [3:0] offset_r
);
	logic signed [3:0] offset_nxt;

	always_comb begin
		case (code)
			scp_pkg::PH_ON_TARGET: offset_nxt = 4'sh0;
			scp_pkg::PH_HALF_EARLY: offset_nxt = -$signed(scp_pkg::HALF_UI_STEPS);
			scp_pkg::PH_ONE_LATE: offset_nxt = $signed(scp_pkg::HALF_UI_STEPS) <<< 1;
			scp_pkg::PH_HALF_LATE: offset_nxt = $signed(scp_pkg::HALF_UI_STEPS);
			default: offset_nxt = 4'sh0;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			offset_r <= 4'sh0;
		end else begin
			offset_r <= offset_nxt;
		end
	end
endmodule

//--- core/scp_pkg.sv
package scp_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [6:0] OFS_SYNC_PHASE = 7'h7B;
	localparam logic [6:0] OFS_SYNC_MON = 7'h7C;
	localparam logic [6:0] OFS_IRQ_CFG = 7'h7D;
	localparam logic [6:0] OFS_GUARD = 7'h7E;
	localparam logic [7:0] RST_SYNC_PHASE = 8'h00;
	localparam logic [7:0] RST_SYNC_MON = 8'h2B;
	localparam logic [7:0] RST_IRQ_CFG = 8'h02;
	localparam logic [7:0] RST_GUARD = 8'h85;
	localparam logic [7:0] KEY_FULL_OPEN = 8'h85;
	localparam logic [7:0] KEY_SINGLE_OPEN = 8'h86;
	localparam int BIT_DERIVED_RATE = 6;
	localparam int BIT_CAL_START = 7;
	localparam int MON_LIMIT_LSB = 4;
	localparam int BIT_PIN_AS_OUTPUT = 2;
	localparam int BIT_TRISTATE = 1;
	localparam int BIT_POLARITY = 0;
	localparam logic [7:0] MASK_SYNC_MON = 8'hF0;
	localparam logic [7:0] MASK_IRQ_CFG = 8'h07;
	localparam logic [1:0] PH_ON_TARGET = 2'h0;
	localparam logic [1:0] PH_HALF_EARLY = 2'h1;
	localparam logic [1:0] PH_ONE_LATE = 2'h2;
	localparam logic [1:0] PH_HALF_LATE = 2'h3;
	localparam logic [1:0] PREC_6M48 = 2'h0;
	localparam logic [1:0] PREC_19M44 = 2'h1;
	localparam logic [1:0] PREC_38M88 = 2'h2;
	localparam logic [3:0] HALF_UI_STEPS = 4'h1;
	localparam int STEP_W = 4;
	localparam logic [2:0] CAL_HOLD = 3'h0;
endpackage

//--- dv/scp_cfg_regs_tb_top.sv
module scp_cfg_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq_ev = 1'b0;
	logic in19 = 1'b0, ochg = 1'b0, pol = 1'b0, act;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00, rdata;
	logic [1:0] ssel = 2'h0, prec;
	logic signed [3:0] ofs;
	logic [2:0] lim;
	logic align, hold, div, ramp, zero, pin_o, pin_oe, seen;
	int err_total = 0;
	int checked = 0;
	logic [3:0] ph_tab [4] = '{4'h0, 4'hF, 4'h2, 4'h1};
	logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h2B, 8'h02, 8'h85};
	always #4 clk = ~clk;
	scp_cfg_regs u_dut (.CORE_CLK(clk), .NRST(nrst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
		.WDATA(wdata), .RDATA(rdata), .IRQ_EVENT(irq_ev), .INPUT_IS_19M44(in19),
		.OFFSET_CHANGED(ochg), .SYNC_SELECT(ssel), .SAMPLE_PRECISION(prec),
		.OCN_ALIGN_EN(align), .SAMPLE_OFFSET(ofs), .MONITOR_LIMIT(lim), .HOLDOVER_REQ(hold),
		.DIVIDER_RESET(div), .OFFSET_RAMP_ACTIVE(ramp), .OFFSET_AT_ZERO(zero),
		.IRQ_PIN_O(pin_o), .IRQ_PIN_OE(pin_oe));
	scp_host u_host (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pol(pol), .seen(seen));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		wr_en <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		chk(rdata, exp);
	endtask
	task automatic conclude;
		$display("checked %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rd(7'h7A + 7'(i), rst_tab[i]);
		$display("test reset values done");
		wr(scp_pkg::OFS_GUARD, 8'h00);
		wr(scp_pkg::OFS_SYNC_MON, 8'h70);
		rd(scp_pkg::OFS_SYNC_MON, 8'h2B);
		wr(scp_pkg::OFS_GUARD, scp_pkg::KEY_SINGLE_OPEN);
		wr(scp_pkg::OFS_SYNC_MON, 8'h50);
		wr(scp_pkg::OFS_SYNC_MON, 8'h30);
		wr(scp_pkg::OFS_IRQ_CFG, 8'h07);
		rd(scp_pkg::OFS_SYNC_MON, 8'h5B);
		rd(scp_pkg::OFS_IRQ_CFG, 8'h02);
		wr(scp_pkg::OFS_GUARD, scp_pkg::KEY_FULL_OPEN);
		$display("test protection done");
		wr(scp_pkg::OFS_SYNC_PHASE, 8'h40);
		in19 <= 1'b1;
		idle(4);
		chk({6'h0, prec}, {6'h0, scp_pkg::PREC_19M44});
		chk({7'h0, align}, 8'h01);
		in19 <= 1'b0;
		idle(3);
		chk({6'h0, prec}, {6'h0, scp_pkg::PREC_38M88});
		for (int i = 0; i < 3; i++) for (int c = 0; c < 4; c++) begin
			ssel <= 2'(i);
			wr(scp_pkg::OFS_SYNC_PHASE, 8'(c << (2 * i)));
			idle(4);
			chk({4'h0, ofs}, {4'h0, ph_tab[c]});
			chk({6'h0, prec}, {6'h0, scp_pkg::PREC_6M48});
			chk({7'h0, align}, 8'h00);
		end
		$display("test sampling done");
		for (int k = 0; k < 8; k++) begin
			wr(scp_pkg::OFS_SYNC_MON, 8'(k << 4));
			idle(3);
			chk({5'h0, lim}, 8'(k));
		end
		ochg <= 1'b1;
		idle(1);
		ochg <= 1'b0;
		idle(2);
		chk({7'h0, ramp}, 8'h01);
		idle(8);
		chk({7'h0, ramp}, 8'h00);
		wr(scp_pkg::OFS_SYNC_MON, 8'h80);
		idle(1);
		for (int n = 0; n < 40 && div !== 1'b1; n++) @(posedge clk);
		chk({5'h0, hold, div, zero}, 8'h07);
		for (int n = 0; n < 40 && hold !== 1'b0; n++) @(posedge clk);
		chk({7'h0, hold}, 8'h00);
		$display("test monitor and calibration done");
		for (int k = 0; k < 16; k++) begin
			wr(scp_pkg::OFS_IRQ_CFG, 8'(k & 7));
			irq_ev <= k[3];
			pol <= k[0];
			idle(4);
			act = k[2] | k[3];
			chk({7'h0, pin_oe}, {7'h0, act | ~k[1]});
			chk({7'h0, pin_o}, {7'h0, act ~^ k[0]});
			chk({7'h0, seen}, {7'h0, act});
		end
		$display("test irq pin done");
		conclude;
	end
	initial begin
		repeat (3000) @(posedge clk);
		$display("MISMATCH t=%0t watchdog expired", $time);
		err_total++;
		conclude;
	end
endmodule
bind scp_cfg_regs scp_chk u_chk (.CORE_CLK, .NRST, .WR_EN, .ADDR, .WDATA, .IRQ_EVENT,
	.INPUT_IS_19M44, .SAMPLE_PRECISION, .OCN_ALIGN_EN, .SAMPLE_OFFSET, .MONITOR_LIMIT,
	.HOLDOVER_REQ, .DIVIDER_RESET, .OFFSET_AT_ZERO, .IRQ_PIN_OE);

//--- dv/scp_chk_asserts.sv
module scp_chk (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic WR_EN,
	input wire logic [6:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic IRQ_EVENT,
	input wire logic INPUT_IS_19M44,
	input wire logic [1:0] SAMPLE_PRECISION,
	input wire logic OCN_ALIGN_EN,
	input wire logic signed [3:0] SAMPLE_OFFSET,
	input wire logic [2:0] MONITOR_LIMIT,
	input wire logic HOLDOVER_REQ,
	input wire logic DIVIDER_RESET,
	input wire logic OFFSET_AT_ZERO,
	input wire logic IRQ_PIN_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	sequence s_key(k);
		WR_EN && ADDR == scp_pkg::OFS_GUARD && WDATA == k;
	endsequence
	sequence s_mon;
		WR_EN && ADDR == scp_pkg::OFS_SYNC_MON;
	endsequence
	sequence s_at_zero;
		DIVIDER_RESET && OFFSET_AT_ZERO;
	endsequence
	sequence s_release;
		!DIVIDER_RESET ##[0:20] !HOLDOVER_REQ;
	endsequence
	AST_LOCKED: assert property (s_key(8'h00) ##1 s_mon |-> ##2 $stable(MONITOR_LIMIT))
		else $error("locked write took effect");
	AST_SINGLE: assert property (s_key(8'h86) ##1 s_mon ##1 s_mon |-> ##2 $stable(MONITOR_LIMIT))
		else $error("second single write took effect");
	AST_RATE_LOW: assert property (!OCN_ALIGN_EN |-> SAMPLE_PRECISION == scp_pkg::PREC_6M48)
		else $error("precision not 6.48");
	AST_RATE_19: assert property ((OCN_ALIGN_EN && INPUT_IS_19M44) [*3] |->
		SAMPLE_PRECISION == scp_pkg::PREC_19M44) else $error("precision not 19.44");
	AST_RATE_38: assert property ((OCN_ALIGN_EN && !INPUT_IS_19M44) [*3] |->
		SAMPLE_PRECISION == scp_pkg::PREC_38M88) else $error("precision not 38.88");
	AST_OFS_CODE: assert property (SAMPLE_OFFSET inside {4'h0, 4'h1, 4'h2, 4'hF})
		else $error("offset out of code set");
	AST_CAL_SEQ: assert property ($rose(HOLDOVER_REQ) |-> ##[1:20] s_at_zero ##1 s_release)
		else $error("calibration sequence broken");
	AST_DRIVE_ACT: assert property (IRQ_EVENT |=> IRQ_PIN_OE)
		else $error("active pin not driven");
endmodule

//--- dv/scp_host.sv
module scp_host (
	input wire logic clk,
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic pol,
	output logic seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_r = 1'b0;
	logic level;
	// Released pin has no pull: hold the inverse of the last driven level
	assign level = pin_oe ? pin_o : ~last_r;
	always_ff @(posedge clk) begin
		if (pin_oe) begin
			last_r <= pin_o;
		end
	end
	assign seen = pin_oe && (level == pol);
endmodule
